/* bench/cts_peer.sv */
/*
  Peer light curtain on the shared trigger line, acting as cascade master.
  Assumes the bench resolves the wire from this peer and the block.
*/
`timescale 1ns/10ps
module cts_peer #(
  parameter int unsigned PULSE_CYC = 20  // Short, so edges can come close.
) (
  input  wire logic clk_i,   // System clock.
  input  wire logic rst_n_i, // Reset, active low.
  input  wire logic en_i,    // Peer drives the line.
  input  wire logic idle_i,  // Idle level of the line.
  input  wire logic fire_i,  // Start one trigger pulse.
  output logic      line_o   // Level offered to the wire.
);
  logic [7:0] cnt_r;   // Pulse cycles left.
  logic [7:0] cnt_nxt; // Next pulse count.
  logic       tog_r;   // Pattern shown while released.
  logic       tog_nxt; // Next pattern bit.

  // A fire request starts a pulse; the released pattern flips each cycle.
  always_comb begin
    cnt_nxt = (cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00;
    if (fire_i) begin
      cnt_nxt = 8'(PULSE_CYC);
    end
    tog_nxt = ~tog_r;
  end

  // Registers only.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 8'h00;
      tog_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tog_r <= tog_nxt;
    end
  end

  // A released line must not look stable, so it toggles.
  // The active level is the inverse of idle.
  assign line_o = !en_i ? tog_r : ((cnt_r != 8'h00) ? ~idle_i : idle_i);
endmodule : cts_peer

/* bench/testbench.sv */
/*
  Self-checking bench for the cascade trigger block.
  Assumes cts_pkg, cts_top and cts_peer are compiled first.
*/
`timescale 1ns/10ps
module testbench;
  import cts_pkg::*;
  logic        mclk = 1'b0, arst_n = 1'b0;          // Clock and reset.
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;      // Addresses.
  logic [31:0] wdata = 32'h0, rdata;                // Data.
  logic        awvalid = 1'b0, wvalid = 1'b0;       // Write valids.
  logic        bready = 1'b0, arvalid = 1'b0;       // Handshakes.
  logic        rready = 1'b0;                       // Read ready.
  logic [3:0]  wstrb = 4'hF;                        // Write strobes.
  logic        awready, wready, bvalid, arready;    // Slave readies.
  logic        rvalid, pin_o, pin_oe_n, scan, line; // Outputs, wire.
  logic [1:0]  bresp, rresp;                        // Responses.
  logic        peer_line, peer_en = 1'b0;           // Peer drive.
  logic        peer_idle = 1'b0, peer_fire = 1'b0;  // Peer control.
  int          num_errors = 0, cmp_count = 0;       // Counters.
  int          scans = 0, last_scan = 0, cyc = 0;   // Scan monitor.
  int          base, t1, t2, w;                     // Master timing.
  logic [31:0] r;                                   // Random value.

  always #2.5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  // Scan pulses last one cycle, so the falling edge sees each once.
  always @(negedge mclk) if (scan === 1'b1) begin
    scans++;
    last_scan = cyc;
  end
  // The block wins the wire whenever it drives it.
  assign line = (pin_oe_n === 1'b0) ? pin_o : peer_line;

  cts_top u_dut (.MCLK_I(mclk), .ARST_N_I(arst_n), .AWADDR_I(awaddr),
    .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
    .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
    .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr),
    .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
    .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
    .TRIG_PIN_I(line), .TRIG_PIN_O(pin_o), .TRIG_PIN_OE_N_O(pin_oe_n),
    .SCAN_START_O(scan));
  cts_peer u_peer (.clk_i(mclk), .rst_n_i(arst_n), .en_i(peer_en),
    .idle_i(peer_idle), .fire_i(peer_fire), .line_o(peer_line));

  // Compares one value and reports a mismatch at once.
  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task results;
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // One write; ready and valid are sampled on the falling edge.
  task axi_wr(input logic [7:0] a, input logic [31:0] d,
              input logic [1:0] er);
    logic aw_t, w_t, b_t, aw_d, w_d, done;
    logic [1:0] rs;
    int n;
    aw_d = 1'b0;
    w_d = 1'b0;
    done = 1'b0;
    rs = 2'h3;
    @(posedge mclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 100 && !done; n++) begin
      @(negedge mclk);
      aw_t = (awready === 1'b1) && !aw_d;
      w_t = (wready === 1'b1) && !w_d;
      b_t = (bvalid === 1'b1);
      rs = bresp;
      @(posedge mclk);
      if (aw_t) begin awvalid <= 1'b0; aw_d = 1'b1; end
      if (w_t) begin wvalid <= 1'b0; w_d = 1'b1; end
      if (b_t) begin bready <= 1'b0; done = 1'b1; end
    end
    check({31'h0, done}, 32'h1);
    check({30'h0, rs}, {30'h0, er});
  endtask : axi_wr

  // One read, checked against the expected data and response.
  task axi_rd(input logic [7:0] a, input logic [31:0] ed,
              input logic [1:0] er);
    logic ar_t, ar_d, done;
    logic [31:0] d;
    logic [1:0] rs;
    int n;
    ar_d = 1'b0;
    done = 1'b0;
    @(posedge mclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 100 && !done; n++) begin
      @(negedge mclk);
      ar_t = (arready === 1'b1) && !ar_d;
      done = (rvalid === 1'b1);
      d = rdata;
      rs = rresp;
      @(posedge mclk);
      if (ar_t) begin arvalid <= 1'b0; ar_d = 1'b1; end
      if (done) rready <= 1'b0;
    end
    check(d, ed);
    check({30'h0, rs}, {30'h0, er});
  endtask : axi_rd

  task fire;
    @(posedge mclk) peer_fire <= 1'b1;
    @(posedge mclk) peer_fire <= 1'b0;
  endtask : fire

  // Configures a slave, fires the peer and counts the scans that follow.
  task slave_run(input logic [23:0] d, input logic pol, input logic [3:0] fn,
                 input logic en, input logic twice, input int exp_n);
    int b, t0, lo;
    lo = d * US_CYCLES;
    axi_wr(ADDR_CASC, 32'h0, RESP_OKAY);
    peer_idle <= pol;
    peer_en <= 1'b1;
    axi_wr(ADDR_PIN, {12'h000, fn, 14'h0000, pol, 1'b1}, RESP_OKAY);
    axi_wr(ADDR_DELAY, {8'h00, d}, RESP_OKAY);
    axi_wr(ADDR_CASC, {31'h0, en}, RESP_OKAY);
    repeat (10) @(posedge mclk);
    check({31'h0, pin_oe_n}, 32'h1);
    b = scans;
    fire();
    t0 = cyc;
    if (twice) begin
      repeat (lo / 2) @(posedge mclk);
      fire();
      t0 = cyc;
    end
    repeat (lo + 2 * US_CYCLES) @(posedge mclk);
    check(scans - b, exp_n);
    if (exp_n != 0) begin
      w = last_scan - t0;
      check({31'h0, w >= lo - 2 && w <= lo + US_CYCLES + 8}, 32'h1);
    end
  endtask : slave_run

  // Waits for a rising level on the wire and returns its cycle.
  task wait_rise(output int t);
    logic p;
    int n;
    p = 1'b1;
    t = -1;
    for (n = 0; n < 210000 && t < 0; n++) begin
      @(negedge mclk);
      if (!p && line === 1'b1) t = cyc;
      p = (line === 1'b1);
    end
    check({31'h0, t >= 0}, 32'h1);
  endtask : wait_rise

  initial begin
    void'($urandom(32'hEF3F));
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    axi_rd(ADDR_CASC, CASC_RST, RESP_OKAY);
    axi_rd(ADDR_CYCLE, {16'h0000, CYCLE_RST}, RESP_OKAY);
    axi_rd(ADDR_DELAY, {8'h00, DELAY_RST}, RESP_OKAY);
    axi_rd(ADDR_PIN, PIN_RST, RESP_OKAY);
    axi_rd(8'h14, 32'h0, RESP_SLVERR);
    axi_wr(8'h14, 32'hFFFF_FFFF, RESP_SLVERR);
    axi_wr(ADDR_STAT, 32'hFFFF_FFFF, RESP_OKAY);
    repeat (4) begin
      r = $urandom;
      axi_wr(ADDR_DELAY, r, RESP_OKAY);
      axi_rd(ADDR_DELAY, {8'h00, r[23:0]}, RESP_OKAY);
    end
    // Only byte lane 1 of a strobed write lands.
    wstrb <= 4'h2;
    axi_wr(ADDR_DELAY, 32'hAABB_CCDD, RESP_OKAY);
    wstrb <= 4'hF;
    axi_rd(ADDR_DELAY, {8'h00, r[23:16], 8'hCC, r[7:0]}, RESP_OKAY);
    slave_run(24'd4, 1'b0, IFN_TRIG_IN, 1'b1, 1'b0, 1);
    slave_run(24'd4, 1'b0, IFN_TRIG_IN, 1'b1, 1'b1, 1);
    slave_run(24'd3, 1'b1, IFN_TRIG_IN, 1'b1, 1'b0, 1);
    // Third unit waits for both earlier units, 2 us plus 3 us.
    slave_run(24'd2 + 24'd3, 1'b0, IFN_TRIG_IN, 1'b1, 1'b0, 1);
    slave_run(24'd3, 1'b0, IFN_TRIG_IN, 1'b0, 1'b0, 0);
    slave_run(24'd3, 1'b0, 4'h2, 1'b1, 1'b0, 0);
    repeat (3) begin
      r = $urandom;
      slave_run(24'(1 + r % 6), r[8], IFN_TRIG_IN, 1'b1, 1'b0, 1);
    end
    // Master with a 1 ms period; the peer lets go of the wire.
    peer_en <= 1'b0;
    axi_wr(ADDR_PIN, {20'h00000, OFN_TRIG_OUT, 8'h00}, RESP_OKAY);
    axi_wr(ADDR_CYCLE, 32'h1, RESP_OKAY);
    axi_wr(ADDR_CASC, 32'h3, RESP_OKAY);
    repeat (4) @(posedge mclk);
    check({31'h0, pin_oe_n}, 32'h0);
    base = scans;
    wait_rise(t1);
    repeat (4) @(negedge mclk);
    check(scans - base, 1);
    for (w = 4; w < 3000 && line === 1'b1; w++) @(negedge mclk);
    check(w, TRIG_US * US_CYCLES);
    wait_rise(t2);
    check(t2 - t1, MS_PER_US * US_CYCLES);
    results();
  end

  // The master part needs one trigger period of a millisecond and a little
  // more; the slave runs add well under a tenth of that.
  initial begin
    #1300000;
    num_errors++;
    results();
  end
endmodule : testbench

/* verilog/cts_pkg.sv */
/*
  Package for the cascade trigger block: register map of the AXI4-Lite
  slave, field positions, reset values and timing constants.
  Assumes a 200 MHz system clock and 32-bit AXI4-Lite data.
*/
package cts_pkg;

  // Clock rate and the derived tick lengths.
  localparam int unsigned CLK_PERIOD_PS = 5000;             // 5 ns period.
  localparam int unsigned US_PS         = 1000000;          // One microsecond.
  localparam int unsigned US_CYCLES     = US_PS / CLK_PERIOD_PS;
  localparam int unsigned MS_PER_US     = 1000;             // Microseconds.

  // Register byte addresses.
  localparam logic [7:0] ADDR_CASC  = 8'h00;                // Cascade setup.
  localparam logic [7:0] ADDR_CYCLE = 8'h04;                // Master period.
  localparam logic [7:0] ADDR_DELAY = 8'h08;                // Slave delay.
  localparam logic [7:0] ADDR_PIN   = 8'h0C;                // Pin setup.
  localparam logic [7:0] ADDR_STAT  = 8'h10;                // Status.

  // Cascade setup fields.
  localparam int unsigned CASC_EN_BIT   = 0;                // Enable.
  localparam int unsigned CASC_ROLE_BIT = 1;                // 1 master.

  // Pin setup fields.
  localparam int unsigned PIN_DIR_BIT   = 0;                // 1 input.
  localparam int unsigned PIN_POL_BIT   = 1;                // 0 light sw.
  localparam int unsigned PIN_OFN_LSB   = 8;                // Out function.
  localparam int unsigned PIN_IFN_LSB   = 16;               // In function.
  localparam int unsigned FN_W          = 4;                // Function width.
  localparam logic [3:0]  OFN_TRIG_OUT  = 4'h3;             // Trigger out.
  localparam logic [3:0]  IFN_TRIG_IN   = 4'h1;             // Trigger in.

  // Reset values.
  localparam logic [31:0] CASC_RST  = 32'h0000_0000;        // Disabled.
  localparam logic [15:0] CYCLE_RST = 16'h000A;             // 10 ms.
  localparam logic [23:0] DELAY_RST = 24'h00_0000;          // No delay.
  localparam logic [31:0] PIN_RST   = 32'h0000_0001;        // Input.

  // Widths.
  localparam int unsigned CYCLE_W = 16;                     // Milliseconds.
  localparam int unsigned DELAY_W = 24;                     // Microseconds.
  localparam int unsigned PRE_W   = 8;                      // Prescaler.
  localparam int unsigned MSC_W   = 10;                     // us in a ms.

  // Trigger pulse length on the pin in microseconds.
  localparam int unsigned TRIG_US = 10;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;                // Done.
  localparam logic [1:0] RESP_SLVERR = 2'h2;                // Unmapped.

endpackage : cts_pkg

/* verilog/cts_top.sv */
/*
  Cascade trigger logic of one light curtain, with its AXI4-Lite register
  slave. A master unit emits a periodic trigger on the shared pin and
  starts its own scan; a slave unit takes the trigger from the pin and
  starts one scan after a programmed delay.
  Assumes the pin input is synchronous to MCLK_I and that the scan engine
  accepts a one-cycle start pulse.
*/
// Notes on behaviour
// - Cascade acts only while enable is 1.
// - Role 1 makes the unit master, generating trigger.
// - Role 0 makes the unit a waiting slave.
// - Master trigger period is programmed milliseconds.
// - Slave scans after programmed microsecond delay.
// - Pin direction 1 input, 0 output.
// - Switching setting 0 selects light-switching polarity.
// - Output function 3 drives trigger on pin.
// - Input function 1 takes pin as trigger.
`timescale 1ns/10ps
module cts_top (
  input  wire logic        MCLK_I,          // 200 MHz clock.
  input  wire logic        ARST_N_I,        // Async reset, active low.
  input  wire logic [7:0]  AWADDR_I,        // Write address.
  input  wire logic        AWVALID_I,       // Write address valid.
  output logic             AWREADY_O,       // Write address ready.
  input  wire logic [31:0] WDATA_I,         // Write data.
  input  wire logic [3:0]  WSTRB_I,         // Write strobes.
  input  wire logic        WVALID_I,        // Write data valid.
  output logic             WREADY_O,        // Write data ready.
  output logic [1:0]       BRESP_O,         // Write response.
  output logic             BVALID_O,        // Write response valid.
  input  wire logic        BREADY_I,        // Write response ready.
  input  wire logic [7:0]  ARADDR_I,        // Read address.
  input  wire logic        ARVALID_I,       // Read address valid.
  output logic             ARREADY_O,       // Read address ready.
  output logic [31:0]      RDATA_O,         // Read data.
  output logic [1:0]       RRESP_O,         // Read response.
  output logic             RVALID_O,        // Read data valid.
  input  wire logic        RREADY_I,        // Read data ready.
  input  wire logic        TRIG_PIN_I,      // Pin level seen.
  output logic             TRIG_PIN_O,      // Pin level driven.
  output logic             TRIG_PIN_OE_N_O, // Low while driving.
  output logic             SCAN_START_O     // One-cycle scan start.
);
  import cts_pkg::*;

  // Applies the polarity setting; light switching passes the level as is.
  function automatic logic pol(input logic lvl, input logic dark);
    pol = lvl ^ dark;
  endfunction : pol

  // Merges a write word into a register under byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  stb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = stb[i] ? dat[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  // Configuration registers.
  logic [31:0]        casc_r, casc_nxt;       // Enable and role.
  logic [CYCLE_W-1:0] cycle_r, cycle_nxt;     // Master period in ms.
  logic [DELAY_W-1:0] delay_r, delay_nxt;     // Slave delay in us.
  logic [31:0]        pin_r, pin_nxt;         // Pin setup.

  // Bus handshake state.
  logic        aw_r, aw_nxt;                  // Address held.
  logic        w_r, w_nxt;                    // Data held.
  logic [7:0]  awa_r, awa_nxt;                // Held write address.
  logic [31:0] wd_r, wd_nxt;                  // Held write data.
  logic [3:0]  ws_r, ws_nxt;                  // Held strobes.
  logic        bv_r, bv_nxt;                  // Write response valid.
  logic [1:0]  br_r, br_nxt;                  // Write response code.
  logic        rv_r, rv_nxt;                  // Read data valid.
  logic [1:0]  rr_r, rr_nxt;                  // Read response code.
  logic [31:0] rd_r, rd_nxt;                  // Read data.
  logic        awrdy_r, awrdy_nxt;            // Write address ready.
  logic        wrdy_r, wrdy_nxt;              // Write data ready.
  logic        arrdy_r, arrdy_nxt;            // Read address ready.
  logic [31:0] cyc_wr, dly_wr;                // Merged write words.

  // Trigger engine state.
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT} cts_state_t;
  cts_state_t         st_r, st_nxt;           // Slave delay phase.
  logic [PRE_W-1:0]   pre_r, pre_nxt;         // Cycles to one us.
  logic [MSC_W-1:0]   msc_r, msc_nxt;         // us to one ms.
  logic [CYCLE_W-1:0] per_r, per_nxt;         // ms into the period.
  logic [DELAY_W-1:0] dly_r, dly_nxt;         // us into the delay.
  logic [7:0]         pw_r, pw_nxt;           // us left of trigger pulse.
  logic               in_d_r, in_d_nxt;       // Previous trigger level.
  logic               pin_o_r, pin_o_nxt;     // Pin drive.
  logic               oe_n_r, oe_n_nxt;       // Pin enable, low drives.
  logic               scan_r, scan_nxt;       // Scan start pulse.
  logic [15:0]        ntrig_r, ntrig_nxt;     // Triggers seen or sent.

  // Decoded settings.
  logic en, master, dir_in, dark, out_fn, in_fn, us_tick, ms_tick, trig_in;
  logic acting_master, acting_slave;
  logic do_wr, slave_edge;
  always_comb begin
    en      = casc_r[CASC_EN_BIT];
    master  = casc_r[CASC_ROLE_BIT];
    dir_in  = pin_r[PIN_DIR_BIT];
    dark    = pin_r[PIN_POL_BIT];
    out_fn  = pin_r[PIN_OFN_LSB +: FN_W] == OFN_TRIG_OUT;
    in_fn   = pin_r[PIN_IFN_LSB +: FN_W] == IFN_TRIG_IN;
    acting_master = en && master;
    acting_slave  = en && !master;
    us_tick = pre_r == PRE_W'(US_CYCLES - 1);
    ms_tick = us_tick && (msc_r == MSC_W'(MS_PER_US - 1));
    trig_in = pol(TRIG_PIN_I, dark);
    do_wr   = aw_r && w_r && !bv_r;
    slave_edge = acting_slave && dir_in && in_fn && trig_in && !in_d_r;
    cyc_wr  = merge({16'h0000, cycle_r}, wd_r, ws_r);
    dly_wr  = merge({8'h00, delay_r}, wd_r, ws_r);
  end

  // Bus next-state: address and data are taken in either order; the
  // response follows once both are held.
  always_comb begin
    aw_nxt = aw_r;  w_nxt = w_r;  awa_nxt = awa_r;
    wd_nxt = wd_r;  ws_nxt = ws_r;
    bv_nxt = bv_r;  br_nxt = br_r;
    rv_nxt = rv_r;  rr_nxt = rr_r;  rd_nxt = rd_r;
    casc_nxt = casc_r;  cycle_nxt = cycle_r;
    delay_nxt = delay_r;  pin_nxt = pin_r;
    if (AWVALID_I && !aw_r) begin
      aw_nxt = 1'b1;
      awa_nxt = AWADDR_I;
    end
    if (WVALID_I && !w_r) begin
      w_nxt = 1'b1;
      wd_nxt = WDATA_I;
      ws_nxt = WSTRB_I;
    end
    if (do_wr) begin
      aw_nxt = 1'b0;
      w_nxt  = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = RESP_OKAY;
      unique case (awa_r)
        ADDR_CASC:  casc_nxt  = merge(casc_r, wd_r, ws_r);
        ADDR_CYCLE: cycle_nxt = cyc_wr[CYCLE_W-1:0];
        ADDR_DELAY: delay_nxt = dly_wr[DELAY_W-1:0];
        ADDR_PIN:   pin_nxt   = merge(pin_r, wd_r, ws_r);
        ADDR_STAT:  br_nxt    = RESP_OKAY;   // Status writes are ignored.
        default:    br_nxt    = RESP_SLVERR; // Unmapped address.
      endcase
    end else if (bv_r && BREADY_I) begin
      bv_nxt = 1'b0;
    end
    if (ARVALID_I && !rv_r) begin
      rv_nxt = 1'b1;
      rr_nxt = RESP_OKAY;
      unique case (ARADDR_I)
        ADDR_CASC:  rd_nxt = casc_r;
        ADDR_CYCLE: rd_nxt = {16'h0000, cycle_r};
        ADDR_DELAY: rd_nxt = {8'h00, delay_r};
        ADDR_PIN:   rd_nxt = pin_r;
        ADDR_STAT:  rd_nxt = {ntrig_r, 12'h000, st_r == ST_WAIT,
                              oe_n_r, pin_o_r, in_d_r};
        default: begin
          rd_nxt = 32'h0000_0000;
          rr_nxt = RESP_SLVERR;
        end
      endcase
    end else if (rv_r && RREADY_I) begin
      rv_nxt = 1'b0;
    end
    // Readies live in flops of their own so every port leaves a flop.
    awrdy_nxt = !aw_nxt;
    wrdy_nxt  = !w_nxt;
    arrdy_nxt = !rv_nxt;
  end

  // Bus registers.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      aw_r <= 1'b0;  w_r <= 1'b0;  awa_r <= 8'h00;
      wd_r <= 32'h0000_0000;  ws_r <= 4'h0;
      bv_r <= 1'b0;  br_r <= RESP_OKAY;
      rv_r <= 1'b0;  rr_r <= RESP_OKAY;  rd_r <= 32'h0000_0000;
      casc_r <= CASC_RST;  cycle_r <= CYCLE_RST;
      delay_r <= DELAY_RST;  pin_r <= PIN_RST;
      awrdy_r <= 1'b1;  wrdy_r <= 1'b1;  arrdy_r <= 1'b1;
    end else begin
      aw_r <= aw_nxt;  w_r <= w_nxt;  awa_r <= awa_nxt;
      wd_r <= wd_nxt;  ws_r <= ws_nxt;
      bv_r <= bv_nxt;  br_r <= br_nxt;
      rv_r <= rv_nxt;  rr_r <= rr_nxt;  rd_r <= rd_nxt;
      casc_r <= casc_nxt;  cycle_r <= cycle_nxt;
      delay_r <= delay_nxt;  pin_r <= pin_nxt;
      awrdy_r <= awrdy_nxt;  wrdy_r <= wrdy_nxt;  arrdy_r <= arrdy_nxt;
    end
  end

  // Trigger engine next-state. The millisecond time base runs freely while
  // this unit is master, so its period is exact whole milliseconds. A slave
  // restarts the microsecond prescaler at each trigger edge, so its delay
  // is never short; this costs nothing, as only a master uses the
  // millisecond boundaries.
  always_comb begin
    st_nxt = st_r;  dly_nxt = dly_r;  per_nxt = per_r;
    pw_nxt = pw_r;  scan_nxt = 1'b0;  ntrig_nxt = ntrig_r;
    pre_nxt = us_tick ? '0 : pre_r + 1'b1;
    msc_nxt = ms_tick ? '0 : (us_tick ? msc_r + 1'b1 : msc_r);
    in_d_nxt = trig_in;
    oe_n_nxt = dir_in;
    if (pw_r != '0 && us_tick) begin
      pw_nxt = pw_r - 1'b1;
    end
    if (acting_master) begin
      st_nxt = ST_IDLE;
      if (ms_tick) begin
        if (per_r >= cycle_r - 1'b1 || cycle_r == '0) begin
          per_nxt = '0;
          pw_nxt  = 8'(TRIG_US);
          scan_nxt = 1'b1;
          ntrig_nxt = ntrig_r + 1'b1;
        end else begin
          per_nxt = per_r + 1'b1;
        end
      end
    end else begin
      // Park the time base two microsecond ticks short of a boundary, so a
      // new master triggers within two microseconds, after its pin drives.
      per_nxt = '1;
      msc_nxt = MSC_W'(MS_PER_US - 2);
      if (!acting_slave) begin
        pw_nxt = '0;
        st_nxt = ST_IDLE;
      end
    end
    // Slave side: a rising edge restarts the delay and the prescaler, so
    // the delay is counted from the edge itself.
    if (slave_edge) begin
      st_nxt  = ST_WAIT;
      dly_nxt = '0;
      pre_nxt = '0;
      ntrig_nxt = ntrig_r + 1'b1;
    end else if (acting_slave && st_r == ST_WAIT) begin
      if (dly_r >= delay_r) begin
        st_nxt = ST_IDLE;
        scan_nxt = 1'b1;
      end else if (us_tick) begin
        dly_nxt = dly_r + 1'b1;
      end
    end
    // Pin drive only for the trigger-out function; light switching drives
    // the pulse high.
    pin_o_nxt = pol(!dir_in && out_fn && pw_nxt != '0, dark);
  end

  // Trigger engine registers.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_r <= ST_IDLE;  pre_r <= '0;  msc_r <= '0;  per_r <= '0;
      dly_r <= '0;  pw_r <= '0;  in_d_r <= 1'b0;
      pin_o_r <= 1'b0;  oe_n_r <= 1'b1;  scan_r <= 1'b0;
      ntrig_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;  pre_r <= pre_nxt;  msc_r <= msc_nxt;
      per_r <= per_nxt;  dly_r <= dly_nxt;  pw_r <= pw_nxt;
      in_d_r <= in_d_nxt;  pin_o_r <= pin_o_nxt;  oe_n_r <= oe_n_nxt;
      scan_r <= scan_nxt;  ntrig_r <= ntrig_nxt;
    end
  end

  assign AWREADY_O = awrdy_r;
  assign WREADY_O  = wrdy_r;
  assign BVALID_O  = bv_r;
  assign BRESP_O   = br_r;
  assign ARREADY_O = arrdy_r;
  assign RVALID_O  = rv_r;
  assign RRESP_O   = rr_r;
  assign RDATA_O   = rd_r;
  assign TRIG_PIN_O      = pin_o_r;
  assign TRIG_PIN_OE_N_O = oe_n_r;
  assign SCAN_START_O    = scan_r;

  // A disabled unit never starts a scan in the next cycle.
  chk_disabled_no_scan: assert property (@(posedge MCLK_I)
    disable iff (!ARST_N_I) !en |=> !scan_r)
    else $error("scan started while cascade disabled");
  // Pin direction follows the setting one cycle later.
  chk_pin_dir: assert property (@(posedge MCLK_I)
    disable iff (!ARST_N_I) 1'b1 |=> oe_n_r == $past(dir_in))
    else $error("pin enable does not follow direction");
  // A slave trigger edge leads to the waiting state.
  chk_slave_edge: assert property (@(posedge MCLK_I)
    disable iff (!ARST_N_I)
    acting_slave && dir_in && in_fn && trig_in && !in_d_r |=>
      st_r == ST_WAIT && dly_r == '0)
    else $error("trigger edge did not arm delay");
  // Master scan comes with a trigger pulse on a ms boundary.
  chk_master_scan: assert property (@(posedge MCLK_I)
    disable iff (!ARST_N_I)
    acting_master && ms_tick && per_r >= cycle_r - 1'b1 |=>
      scan_r && pw_r == 8'(TRIG_US))
    else $error("master trigger without scan");
  // A slave whose delay has run out issues its scan and goes idle.
  sequence seq_delay_done;
    acting_slave && !slave_edge && st_r == ST_WAIT && dly_r >= delay_r;
  endsequence
  sequence seq_scan_idle;
    scan_r && st_r == ST_IDLE;
  endsequence
  chk_slave_scan: assert property (@(posedge MCLK_I)
    disable iff (!ARST_N_I) seq_delay_done |=> seq_scan_idle)
    else $error("slave delay ran out without a scan");
  // A scan start lasts one cycle, so one trigger gives one scan.
  chk_scan_pulse: assert property (@(posedge MCLK_I)
    disable iff (!ARST_N_I) scan_r |=> !scan_r)
    else $error("scan start longer than one cycle");
  // Without the trigger-out function the pin rests at its idle level.
  chk_pin_idle: assert property (@(posedge MCLK_I)
    disable iff (!ARST_N_I) (dir_in || !out_fn) |=> pin_o_r == $past(dark))
    else $error("pin driven without trigger-out function");
endmodule : cts_top
